/* File: src/sfce_consts.svh */
`ifndef SFCE_CONSTS_SVH
`define SFCE_CONSTS_SVH

`define SFCE_CLK_MHZ 10
`define SFCE_BYTE_PROG_TIME_US 20
`define SFCE_SECTOR_ERASE_TIME_US 25000
`define SFCE_BLOCK_ERASE_TIME_US 25000
`define SFCE_CHIP_ERASE_TIME_US 100000
`define SFCE_BUSY_W 24
`define SFCE_BYTE_PROG_CYC `SFCE_BUSY_W'(`SFCE_BYTE_PROG_TIME_US * `SFCE_CLK_MHZ)
`define SFCE_SECTOR_ERASE_CYC `SFCE_BUSY_W'(`SFCE_SECTOR_ERASE_TIME_US * `SFCE_CLK_MHZ)
`define SFCE_BLOCK_ERASE_CYC `SFCE_BUSY_W'(`SFCE_BLOCK_ERASE_TIME_US * `SFCE_CLK_MHZ)
`define SFCE_CHIP_ERASE_CYC `SFCE_BUSY_W'(`SFCE_CHIP_ERASE_TIME_US * `SFCE_CLK_MHZ)

`define SFCE_ADDR_W 17
`define SFCE_TOP_ADDR 17'h1FFFF
`define SFCE_TOP_LVL1 17'h17FFF
`define SFCE_TOP_LVL2 17'h0FFFF
`define SFCE_FIFO_DEPTH 8
`define SFCE_BP_RESET 2'h3
`define SFCE_LAST_ADDR_BYTE 2'h2

`define SFCE_OP_READ 8'h03
`define SFCE_OP_FAST_READ 8'h0B
`define SFCE_OP_PROGRAM 8'h02
`define SFCE_OP_AUTO_INC 8'hAF
`define SFCE_OP_SECTOR_ERASE 8'h20
`define SFCE_OP_BLOCK_ERASE_A 8'h52
`define SFCE_OP_BLOCK_ERASE_B 8'hD8
`define SFCE_OP_CHIP_ERASE_A 8'h60
`define SFCE_OP_CHIP_ERASE_B 8'hC7
`define SFCE_OP_STATUS_READ 8'h05
`define SFCE_OP_STATUS_ARM 8'h50
`define SFCE_OP_STATUS_WRITE 8'h01
`define SFCE_OP_WRITE_ENABLE 8'h06
`define SFCE_OP_WRITE_DISABLE 8'h04
`define SFCE_OP_ID_A 8'h90
`define SFCE_OP_ID_B 8'hAB

// Identification values are arbitrary.
`define SFCE_MFR_ID 8'hA5
`define SFCE_DEV_ID 8'h5A

`define SFCE_ERASE_SECTOR 2'h0
`define SFCE_ERASE_BLOCK 2'h1
`define SFCE_ERASE_CHIP 2'h2

`endif

/* File: src/sfce_pkg.sv */
package sfce_pkg;
  typedef enum logic [8:0] {
    ST_OPCODE = 9'h001,
    ST_ADDRESS = 9'h002,
    ST_DUMMY = 9'h004,
    ST_READ = 9'h008,
    ST_STATUS = 9'h010,
    ST_ID = 9'h020,
    ST_DATA = 9'h040,
    ST_STATUS_DATA = 9'h080,
    ST_IGNORE = 9'h100
  } sfce_state_t;
endpackage

/* File: src/sfce_engine.sv */
`timescale 1ns/100ps
`include "sfce_consts.svh"

module sfce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SFCE_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire same_slot = wr_ptr[AW-1:0] == rd_ptr[AW-1:0];

  assign in_ready = !same_slot || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// Functional notes
// R1: every bus cycle is eight serial clocks.
// R2: address bits above bit 16 ignored.
// R3: read opcode plus address streams data directly.
// R4: read streams with pointer increment until deselect.
// R5: read pointer wraps from top to zero.
// R6: fast read adds one ignored dummy byte.
// R7: program: opcode, address, data, then deselect.
// R8: host programs only erased locations.
// R9: program or erase on protected area dropped.
// R10: program and erase need write latch set.
// R11: auto-increment continues with opcode plus data.
// R12: host waits for busy between auto bytes.
// R13: write disable ends auto-increment programming.
// R14: auto-increment stops at top unprotected address.
// R15: sector erase uses address bits 16..12.
// R16: block erase uses address bits 16..15.
// R17: chip erase refused if anything protected.
// R18: program and erase start at deselect.
// R19: status read accepted even while busy.
// R20: status byte repeats every eight clocks.
// R21: status write only right after arm.
// R22: identification codes alternate, bit 0 selects first.
// R23: input sampled on rising clock, MSB first.
// R24: deselect mid-byte aborts the instruction.
// R25: write enable sets the write latch.
// R26: write disable clears latch and auto mode.
// R27: busy high for the whole internal operation.
module sfce_engine
  import sfce_pkg::*;
#(
  parameter logic [`SFCE_BUSY_W-1:0] PROG_CYCLES = `SFCE_BYTE_PROG_CYC,
  parameter logic [`SFCE_BUSY_W-1:0] SECTOR_CYCLES = `SFCE_SECTOR_ERASE_CYC,
  parameter logic [`SFCE_BUSY_W-1:0] BLOCK_CYCLES = `SFCE_BLOCK_ERASE_CYC,
  parameter logic [`SFCE_BUSY_W-1:0] CHIP_CYCLES = `SFCE_CHIP_ERASE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Serial pins
  input wire logic spi_sel_n,
  input wire logic spi_clk,
  input wire logic spi_din,
  output logic spi_dout,
  output logic spi_dout_oe_n,
  input wire logic write_protect_n,
  // Memory array
  output logic [`SFCE_ADDR_W-1:0] array_rd_addr,
  input wire logic [7:0] array_rd_data,
  output logic [`SFCE_ADDR_W-1:0] array_op_addr,
  output logic [7:0] array_prog_data,
  output logic array_prog,
  output logic array_erase,
  output logic [1:0] array_erase_kind,
  // Status
  output logic [7:0] status
);
  sfce_state_t st;
  sfce_state_t next_st;

  logic [1:0] sel_s;
  logic [2:0] sck_s;
  logic [1:0] din_s;
  logic [1:0] wp_s;
  logic sel_d;
  logic [2:0] bit_cnt;
  logic [6:0] rx_sh;
  logic [1:0] addr_cnt;
  logic [7:0] cmd;
  logic [`SFCE_ADDR_W-1:0] cmd_addr;
  logic [7:0] cmd_data;
  logic cmd_ready;
  logic write_latch_flag;
  logic auto_inc_mode;
  logic [`SFCE_ADDR_W-1:0] auto_ptr;
  logic [1:0] bp;
  logic bpl;
  logic armed;
  logic [`SFCE_BUSY_W-1:0] busy_cnt;
  logic fetch_on;
  logic id_sel;
  logic [7:0] tx_sh;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;

  // Pin synchronisers; protocol logic reads the second stage, and the clock edge detect also reads the third stage.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sel_s <= 2'h3;
      sck_s <= 3'h0;
      din_s <= 2'h0;
      wp_s <= 2'h3;
      sel_d <= 1'b1;
    end else begin
      sel_s <= {sel_s[0], spi_sel_n};
      sck_s <= {sck_s[1:0], spi_clk};
      din_s <= {din_s[0], spi_din};
      wp_s <= {wp_s[0], write_protect_n};
      sel_d <= sel_s[1];
    end
  end

  wire selected = !sel_s[1];
  wire sel_rise = sel_s[1] && !sel_d;
  wire sck_rise = selected && sck_s[1] && !sck_s[2];
  wire sck_fall = selected && !sck_s[1] && sck_s[2];
  wire byte_done = sck_rise && (bit_cnt == 3'h7); // R1
  wire [7:0] rx_byte = {rx_sh, din_s[1]};
  wire [`SFCE_ADDR_W-1:0] full_addr = {cmd_addr[8:0], rx_byte}; // R2
  wire addr_last = byte_done && (addr_cnt == `SFCE_LAST_ADDR_BYTE);
  wire busy = busy_cnt != '0;

  // Opcode decode on the byte just received.
  wire op_read = rx_byte == `SFCE_OP_READ;
  wire op_fast = rx_byte == `SFCE_OP_FAST_READ;
  wire op_prog = rx_byte == `SFCE_OP_PROGRAM;
  wire op_auto = rx_byte == `SFCE_OP_AUTO_INC;
  wire op_sect = rx_byte == `SFCE_OP_SECTOR_ERASE;
  wire op_blk = rx_byte == `SFCE_OP_BLOCK_ERASE_A || rx_byte == `SFCE_OP_BLOCK_ERASE_B;
  wire op_chip = rx_byte == `SFCE_OP_CHIP_ERASE_A || rx_byte == `SFCE_OP_CHIP_ERASE_B;
  wire op_sr = rx_byte == `SFCE_OP_STATUS_READ;
  wire op_arm = rx_byte == `SFCE_OP_STATUS_ARM;
  wire op_swr = rx_byte == `SFCE_OP_STATUS_WRITE;
  wire op_wen = rx_byte == `SFCE_OP_WRITE_ENABLE;
  wire op_wdis = rx_byte == `SFCE_OP_WRITE_DISABLE;
  wire op_id = rx_byte == `SFCE_OP_ID_A || rx_byte == `SFCE_OP_ID_B;
  wire op_with_addr = op_read || op_fast || op_prog || op_auto || op_sect || op_blk || op_id;
  wire op_single = op_chip || op_arm || op_wen || op_wdis;
  // While busy only status read and write disable are taken.
  wire op_allowed = !busy || op_sr || op_wdis; // R19
  wire op_auto_next = op_auto && auto_inc_mode; // R11

  // Decode of the latched opcode.
  wire c_read = cmd == `SFCE_OP_READ;
  wire c_fast = cmd == `SFCE_OP_FAST_READ;
  wire c_id = cmd == `SFCE_OP_ID_A || cmd == `SFCE_OP_ID_B;
  wire c_prog = cmd == `SFCE_OP_PROGRAM;
  wire c_auto = cmd == `SFCE_OP_AUTO_INC;
  wire c_sect = cmd == `SFCE_OP_SECTOR_ERASE;
  wire c_blk = cmd == `SFCE_OP_BLOCK_ERASE_A || cmd == `SFCE_OP_BLOCK_ERASE_B;
  wire c_chip = cmd == `SFCE_OP_CHIP_ERASE_A || cmd == `SFCE_OP_CHIP_ERASE_B;

  always_comb begin
    next_st = st;
    unique case (st)
      ST_OPCODE: begin
        if (byte_done) begin
          if (!op_allowed) begin
            next_st = ST_IGNORE;
          end else if (op_auto_next) begin
            next_st = ST_DATA;
          end else if (op_with_addr) begin
            next_st = ST_ADDRESS;
          end else if (op_sr) begin
            next_st = ST_STATUS; // R19
          end else if (op_swr && armed) begin
            next_st = ST_STATUS_DATA; // R21
          end else begin
            next_st = ST_IGNORE;
          end
        end
      end
      ST_ADDRESS: begin
        if (addr_last) begin
          if (c_fast) begin
            next_st = ST_DUMMY; // R6
          end else if (c_read) begin
            next_st = ST_READ; // R3
          end else if (c_id) begin
            next_st = ST_ID;
          end else if (c_prog || c_auto) begin
            next_st = ST_DATA; // R7
          end else begin
            next_st = ST_IGNORE;
          end
        end
      end
      ST_DUMMY: begin
        if (byte_done) begin
          next_st = ST_READ; // R6
        end
      end
      ST_DATA, ST_STATUS_DATA: begin
        if (byte_done) begin
          next_st = ST_IGNORE;
        end
      end
      ST_READ, ST_STATUS, ST_ID, ST_IGNORE: begin
        next_st = st;
      end
    endcase
    if (!selected) begin
      next_st = ST_OPCODE; // R4
    end
  end

  wire set_ready = byte_done && (
    (st == ST_OPCODE && op_allowed && op_single) ||
    (st == ST_ADDRESS && addr_cnt == `SFCE_LAST_ADDR_BYTE && (c_sect || c_blk)) ||
    st == ST_DATA || st == ST_STATUS_DATA);

  // A command runs only on a clean byte boundary at deselect.
  wire exec = sel_rise && cmd_ready && (bit_cnt == 3'h0); // R18 R24

  wire addr_prot = (bp == 2'h3) || (bp == 2'h2 && cmd_addr[16]) ||
                   (bp == 2'h1 && cmd_addr[16:15] == 2'h3);
  wire [`SFCE_ADDR_W-1:0] top_unprot = (bp == 2'h0) ? `SFCE_TOP_ADDR :
                                       (bp == 2'h1) ? `SFCE_TOP_LVL1 : `SFCE_TOP_LVL2;
  wire do_prog = exec && (c_prog || c_auto) && write_latch_flag && !addr_prot; // R9 R10
  wire do_erase = exec && write_latch_flag && // R10
                  (((c_sect || c_blk) && !addr_prot) || (c_chip && bp == 2'h0)); // R9 R17
  wire auto_end = cmd_addr == top_unprot;
  wire ex_wen = exec && cmd == `SFCE_OP_WRITE_ENABLE;
  wire ex_wdis = exec && cmd == `SFCE_OP_WRITE_DISABLE;
  wire ex_swr = exec && cmd == `SFCE_OP_STATUS_WRITE && (wp_s[1] || !bpl);
  wire [1:0] erase_kind = c_chip ? `SFCE_ERASE_CHIP :
                          c_blk ? `SFCE_ERASE_BLOCK : `SFCE_ERASE_SECTOR;
  wire [`SFCE_BUSY_W-1:0] erase_time = c_chip ? CHIP_CYCLES :
                                       c_blk ? BLOCK_CYCLES : SECTOR_CYCLES;
  wire [7:0] status_now = {bpl, auto_inc_mode, 2'h0, bp, write_latch_flag, busy};

  // Serial input shifter.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= 3'h0;
      rx_sh <= 7'h00;
    end else if (!selected) begin
      bit_cnt <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1; // R1
      rx_sh <= rx_byte[6:0]; // R23
    end
  end

  // Instruction capture.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= ST_OPCODE;
      addr_cnt <= 2'h0;
      cmd <= 8'h00;
      cmd_addr <= '0;
      cmd_data <= 8'h00;
      cmd_ready <= 1'b0;
    end else begin
      st <= next_st;
      cmd_ready <= selected && (cmd_ready || set_ready);
      if (st == ST_OPCODE && byte_done) begin
        cmd <= rx_byte;
        addr_cnt <= 2'h0;
        if (op_auto_next) begin
          cmd_addr <= auto_ptr; // R11
        end
      end
      if (st == ST_ADDRESS && byte_done) begin
        cmd_addr <= full_addr;
        addr_cnt <= addr_cnt + 2'h1;
      end
      if ((st == ST_DATA || st == ST_STATUS_DATA) && byte_done) begin
        cmd_data <= rx_byte;
      end
    end
  end

  // Write latch, auto-increment mode, protection bits and arming.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      write_latch_flag <= 1'b0;
      auto_inc_mode <= 1'b0;
      auto_ptr <= '0;
      bp <= `SFCE_BP_RESET;
      bpl <= 1'b0;
      armed <= 1'b0;
    end else begin
      if (ex_wen) begin
        write_latch_flag <= 1'b1; // R25
      end else if (ex_wdis) begin
        write_latch_flag <= 1'b0; // R26
        auto_inc_mode <= 1'b0; // R13 R26
      end else if (do_prog && c_auto) begin
        auto_inc_mode <= !auto_end; // R14
        write_latch_flag <= !auto_end; // R14
        auto_ptr <= cmd_addr + 1'b1;
      end else if (do_prog || do_erase) begin
        write_latch_flag <= 1'b0;
      end
      if (ex_swr) begin
        bp <= cmd_data[3:2];
        bpl <= cmd_data[7];
      end
      // Any completed opcode other than arm disarms the status write.
      if (sel_rise && st != ST_OPCODE) begin
        armed <= exec && cmd == `SFCE_OP_STATUS_ARM; // R21
      end
    end
  end

  // Self-timed operation and array strobes.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt <= '0;
      array_prog <= 1'b0;
      array_erase <= 1'b0;
      array_erase_kind <= `SFCE_ERASE_SECTOR;
      array_op_addr <= '0;
      array_prog_data <= 8'h00;
      status <= 8'h00;
    end else begin
      array_prog <= do_prog;
      array_erase <= do_erase;
      status <= status_now;
      if (do_prog) begin
        busy_cnt <= PROG_CYCLES; // R27
        array_op_addr <= cmd_addr;
        array_prog_data <= cmd_data;
      end else if (do_erase) begin
        busy_cnt <= erase_time; // R27
        array_erase_kind <= erase_kind;
        array_op_addr <= cmd_addr; // R15 R16
      end else if (busy) begin
        busy_cnt <= busy_cnt - 1'b1; // R27
      end
    end
  end

  // Read prefetch: the FIFO fills ahead and stalls the fetcher when full.
  wire start_fetch = st == ST_ADDRESS && addr_last && (c_read || c_fast);
  wire fetch_push = fetch_on && fifo_in_ready;
  wire tx_on = st == ST_READ || st == ST_STATUS || st == ST_ID;
  wire tx_load = sck_fall && tx_on && bit_cnt == 3'h0;
  wire fifo_pop = tx_load && st == ST_READ && fifo_valid;
  wire [7:0] id_code = id_sel ? `SFCE_DEV_ID : `SFCE_MFR_ID;
  wire [7:0] tx_byte = (st == ST_READ) ? fifo_data :
                       (st == ST_STATUS) ? status_now : id_code; // R20 R22

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_on <= 1'b0;
      array_rd_addr <= '0;
    end else if (!selected) begin
      fetch_on <= 1'b0; // R4
    end else if (start_fetch) begin
      fetch_on <= 1'b1;
      array_rd_addr <= full_addr; // R3
    end else if (fetch_push) begin
      array_rd_addr <= array_rd_addr + 1'b1; // R4 R5
    end
  end

  sfce_fifo #(
    .WIDTH(8),
    .DEPTH(`SFCE_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .flush(!selected),
    .in_valid(fetch_on),
    .in_ready(fifo_in_ready),
    .in_data(array_rd_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Serial output: a new byte is loaded on the falling edge after each byte boundary.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sh <= 8'h00;
      spi_dout <= 1'b0;
      spi_dout_oe_n <= 1'b1;
      id_sel <= 1'b0;
    end else begin
      spi_dout_oe_n <= !(tx_on && selected);
      if (st == ST_ADDRESS && addr_last) begin
        id_sel <= rx_byte[0]; // R22
      end else if (tx_load && st == ST_ID) begin
        id_sel <= !id_sel; // R22
      end
      if (tx_load) begin
        spi_dout <= tx_byte[7];
        tx_sh <= {tx_byte[6:0], 1'b0};
      end else if (sck_fall && tx_on) begin
        spi_dout <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end
endmodule

/* File: test/sfce_engine_monitor.sv */
`timescale 1ns/100ps
`include "sfce_consts.svh"
module sfce_engine_monitor
  import sfce_pkg::*;
#(
  parameter logic [`SFCE_BUSY_W-1:0] PROG_CYCLES = `SFCE_BYTE_PROG_CYC,
  parameter logic [`SFCE_BUSY_W-1:0] SECTOR_CYCLES = `SFCE_SECTOR_ERASE_CYC,
  parameter logic [`SFCE_BUSY_W-1:0] BLOCK_CYCLES = `SFCE_BLOCK_ERASE_CYC,
  parameter logic [`SFCE_BUSY_W-1:0] CHIP_CYCLES = `SFCE_CHIP_ERASE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Serial pins
  input wire logic spi_sel_n,
  input wire logic spi_dout_oe_n,
  // Array side
  input wire logic [`SFCE_ADDR_W-1:0] array_op_addr,
  input wire logic array_prog,
  input wire logic array_erase,
  input wire logic [1:0] array_erase_kind,
  // Status
  input wire logic [7:0] status
);
  logic [`SFCE_BUSY_W-1:0] busy_len;
  logic [`SFCE_BUSY_W-1:0] want;
  logic [`SFCE_BUSY_W-1:0] next_want;
  wire [1:0] bp = status[3:2];
  wire any_op = array_prog || array_erase;
  wire is_chip = array_erase && array_erase_kind == `SFCE_ERASE_CHIP;
  wire guarded = bp == 2'h3 || (bp == 2'h2 && array_op_addr[16])
    || (bp == 2'h1 && array_op_addr[16:15] == 2'h3);
  assign next_want = array_prog ? PROG_CYCLES
    : array_erase_kind == `SFCE_ERASE_SECTOR ? SECTOR_CYCLES
    : array_erase_kind == `SFCE_ERASE_BLOCK ? BLOCK_CYCLES : CHIP_CYCLES;
  // The length check allows one cycle of slack for the status register lag.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_len <= '0;
      want <= '0;
    end else begin
      busy_len <= status[0] ? busy_len + 1'b1 : '0;
      if (any_op) begin
        want <= next_want;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_busy_follows_op: assert property (any_op |=> status[0])
    else $error("busy flag missing after array operation");
  a_busy_exact_len: assert property ($fell(status[0]) |->
    busy_len + 1'b1 >= want && busy_len <= want + 1'b1)
    else $error("busy length differs from operation time");
  a_op_when_idle: assert property (any_op |-> !status[0])
    else $error("array operation started while busy");
  a_op_needs_latch: assert property (any_op |-> status[1])
    else $error("array operation without write latch");
  a_target_open: assert property ((array_prog || (array_erase && !is_chip)) |-> !guarded)
    else $error("operation on protected area");
  a_chip_all_open: assert property (is_chip |-> bp == 2'h0)
    else $error("chip erase with protection set");
  a_op_after_deselect: assert property (any_op |-> spi_sel_n && $past(spi_sel_n, 3))
    else $error("array operation while selected");
  a_pulse_one_cycle: assert property (any_op |=> !any_op)
    else $error("array pulse longer than one cycle");
  a_idle_released: assert property (spi_sel_n [*6] |-> spi_dout_oe_n)
    else $error("output driven while deselected");
  a_erase_kind_legal: assert property (array_erase |-> array_erase_kind != 2'h3)
    else $error("illegal erase kind");
  c_program: cover property (array_prog);
  c_chip_erase: cover property (is_chip);
  c_auto_end: cover property ($fell(status[6]));
endmodule
bind sfce_engine sfce_engine_monitor #(
  .PROG_CYCLES(PROG_CYCLES),
  .SECTOR_CYCLES(SECTOR_CYCLES),
  .BLOCK_CYCLES(BLOCK_CYCLES),
  .CHIP_CYCLES(CHIP_CYCLES)
) u_monitor (
  .mclk(mclk),
  .reset_n(reset_n),
  .spi_sel_n(spi_sel_n),
  .spi_dout_oe_n(spi_dout_oe_n),
  .array_op_addr(array_op_addr),
  .array_prog(array_prog),
  .array_erase(array_erase),
  .array_erase_kind(array_erase_kind),
  .status(status)
);

/* File: test/sfce_host.sv */
`timescale 1ns/100ps
module sfce_host
  import sfce_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Serial pins
  input wire logic spi_dout,
  output logic spi_sel_n,
  output logic spi_clk,
  output logic spi_din
);
  initial begin
    spi_sel_n = 1'b1;
    spi_clk = 1'b0;
    spi_din = 1'b0;
  end
  task automatic open_frame();
    @(posedge mclk);
    spi_sel_n <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // Four mclk low then four high; the reply is taken just before the next fall.
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      @(posedge mclk);
      spi_clk <= 1'b0;
      spi_din <= tx[7 - i];
      repeat (4) @(posedge mclk);
      spi_clk <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      rx = {rx[6:0], spi_dout};
    end
  endtask
  // A released data line shows the inverse of its last bit, never a stale copy.
  task automatic close_frame();
    @(posedge mclk);
    spi_clk <= 1'b0;
    spi_din <= ~spi_din;
    repeat (2) @(posedge mclk);
    spi_sel_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
endmodule

/* File: test/test_sfce_engine.sv */
`timescale 1ns/100ps
`include "sfce_consts.svh"
module test_sfce_engine
  import sfce_pkg::*;
;
  typedef struct {logic [7:0] op; logic [23:0] a; int na; int nd; logic [7:0] e0;
    logic [7:0] e1;} sfce_rd_row_t;
  typedef struct {logic [7:0] op; logic [23:0] a; logic [16:0] lo; logic [16:0] hi;} sfce_er_row_t;
  logic mclk, reset_n, write_protect_n, spi_dout, spi_dout_oe_n;
  wire spi_sel_n, spi_clk, spi_din;
  logic [16:0] array_rd_addr, array_op_addr, er_lo;
  logic [7:0] array_rd_data, array_prog_data, status;
  logic array_prog, array_erase;
  logic [1:0] array_erase_kind;
  logic [7:0] mem [0:131071];
  int er_n, n_errors = 0, samples_checked = 0;
  sfce_rd_row_t rows [5] = '{'{`SFCE_OP_READ, 24'hFFFFFF, 3, 0, 8'h3C, 8'hC3},
    '{`SFCE_OP_FAST_READ, 24'hFE0010, 3, 1, 8'hD3, 8'hD2},
    '{`SFCE_OP_ID_A, 24'h000000, 3, 0, `SFCE_MFR_ID, `SFCE_DEV_ID},
    '{`SFCE_OP_ID_B, 24'h000001, 3, 0, `SFCE_DEV_ID, `SFCE_MFR_ID},
    '{`SFCE_OP_STATUS_READ, 24'h000000, 0, 0, 8'h0C, 8'h0C}};
  sfce_er_row_t erows [5] = '{'{8'h20, 24'hF01ABC, 17'h01000, 17'h01FFF},
    '{8'h52, 24'h008123, 17'h08000, 17'h0FFFF}, '{8'hD8, 24'h01A000, 17'h18000, 17'h1FFFF},
    '{8'hC7, 24'h000000, 17'h00000, 17'h1FFFF}, '{8'h60, 24'h000000, 17'h00000, 17'h1FFFF}};
  wire spi_line = spi_dout_oe_n ? ~spi_dout : spi_dout;
  sfce_host host (.mclk(mclk), .spi_dout(spi_line), .spi_sel_n(spi_sel_n),
    .spi_clk(spi_clk), .spi_din(spi_din));
  sfce_engine #(.PROG_CYCLES(24'h0000C8), .SECTOR_CYCLES(24'h00012C),
    .BLOCK_CYCLES(24'h00012C), .CHIP_CYCLES(24'h000190)) uut (.mclk(mclk),
    .reset_n(reset_n), .spi_sel_n(spi_sel_n), .spi_clk(spi_clk), .spi_din(spi_din),
    .spi_dout(spi_dout), .spi_dout_oe_n(spi_dout_oe_n), .write_protect_n(write_protect_n),
    .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data),
    .array_op_addr(array_op_addr), .array_prog_data(array_prog_data),
    .array_prog(array_prog), .array_erase(array_erase),
    .array_erase_kind(array_erase_kind), .status(status));
  function automatic logic [7:0] pat(logic [16:0] a);
    return a[7:0] ^ 8'hC3;
  endfunction
  // The array answers in the same cycle and programming can only clear bits.
  assign array_rd_data = mem[array_rd_addr];
  assign er_lo = array_erase_kind == `SFCE_ERASE_SECTOR ? {array_op_addr[16:12], 12'h000}
    : array_erase_kind == `SFCE_ERASE_BLOCK ? {array_op_addr[16:15], 15'h0000} : 17'h00000;
  assign er_n = array_erase_kind == `SFCE_ERASE_SECTOR ? 4096
    : array_erase_kind == `SFCE_ERASE_BLOCK ? 32768 : 131072;
  always @(posedge mclk) begin
    if (array_prog) mem[array_op_addr] <= mem[array_op_addr] & array_prog_data;
    if (array_erase) for (int i = 0; i < er_n; i++) mem[er_lo + 17'(i)] <= 8'hFF;
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  task automatic send(input logic [7:0] q[$]);
    logic [7:0] r;
    host.open_frame();
    foreach (q[i]) host.xfer(q[i], 8, r);
    host.close_frame();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (status[0] !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 2000) begin
      n_errors++;
      close_out();
    end
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    close_out();
  end
  initial begin
    logic [7:0] r, r0, r1;
    reset_n = 1'b0;
    write_protect_n = 1'b1;
    for (int i = 0; i < 131072; i++) mem[i] = pat(17'(i));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("status_reset", 8'h0C, status);
    foreach (rows[k]) begin
      host.open_frame();
      host.xfer(rows[k].op, 8, r);
      for (int i = 0; i < rows[k].na; i++) host.xfer(rows[k].a[23 - 8 * i -: 8], 8, r);
      repeat (rows[k].nd) host.xfer(8'h96, 8, r);
      host.xfer(8'h00, 8, r0);
      host.xfer(8'h00, 8, r1);
      host.close_frame();
      chk("stream_first", rows[k].e0, r0);
      chk("stream_next", rows[k].e1, r1);
    end
    host.open_frame();
    host.xfer(`SFCE_OP_WRITE_ENABLE, 5, r);
    host.close_frame();
    chk("partial_abort", 8'h0C, status);
    send('{`SFCE_OP_STATUS_ARM});
    send('{`SFCE_OP_WRITE_DISABLE});
    send('{`SFCE_OP_STATUS_WRITE, 8'h00});
    chk("arm_lost", 8'h0C, status);
    send('{`SFCE_OP_STATUS_ARM});
    send('{`SFCE_OP_STATUS_WRITE, 8'h00});
    chk("arm_used", 8'h00, status);
    send('{`SFCE_OP_PROGRAM, 8'h00, 8'h01, 8'h00, 8'h00});
    chk("prog_no_latch", 8'hC3, mem[17'h00100]);
    send('{`SFCE_OP_WRITE_ENABLE});
    chk("latch_set", 8'h02, status);
    send('{`SFCE_OP_PROGRAM, 8'h00, 8'h01, 8'h00, 8'h0F});
    host.open_frame();
    host.xfer(`SFCE_OP_STATUS_READ, 8, r);
    host.xfer(8'h00, 8, r0);
    host.close_frame();
    chk("status_busy", 8'h01, r0);
    wait_idle();
    chk("prog_data", 8'h03, mem[17'h00100]);
    chk("prog_done", 8'h00, status);
    send('{`SFCE_OP_STATUS_ARM});
    send('{`SFCE_OP_STATUS_WRITE, 8'h04});
    send('{`SFCE_OP_WRITE_ENABLE});
    send('{`SFCE_OP_SECTOR_ERASE, 8'h01, 8'h80, 8'h00});
    send('{`SFCE_OP_CHIP_ERASE_A});
    chk("protect_status", 8'h06, status);
    chk("protect_data", 8'hC3, mem[17'h18000]);
    send('{`SFCE_OP_STATUS_ARM});
    send('{`SFCE_OP_STATUS_WRITE, 8'h00});
    foreach (erows[k]) begin
      send('{`SFCE_OP_WRITE_ENABLE});
      if (erows[k].lo == 17'h00000) send('{erows[k].op});
      else send('{erows[k].op, erows[k].a[23:16], erows[k].a[15:8], erows[k].a[7:0]});
      wait_idle();
      chk("erase_low", 8'hFF, mem[erows[k].lo]);
      chk("erase_high", 8'hFF, mem[erows[k].hi]);
      if (erows[k].lo != 17'h00000) chk("erase_below", pat(erows[k].lo - 1'b1),
        mem[erows[k].lo - 1'b1]);
    end
    send('{`SFCE_OP_WRITE_ENABLE});
    send('{`SFCE_OP_AUTO_INC, 8'h01, 8'hFF, 8'hFE, 8'h11});
    wait_idle();
    chk("auto_mode", 8'h42, status);
    send('{`SFCE_OP_AUTO_INC, 8'h22});
    wait_idle();
    chk("auto_top_exit", 8'h00, status);
    chk("auto_byte0", 8'h11, mem[17'h1FFFE]);
    chk("auto_byte1", 8'h22, mem[17'h1FFFF]);
    send('{`SFCE_OP_WRITE_ENABLE});
    send('{`SFCE_OP_AUTO_INC, 8'h00, 8'h00, 8'h00, 8'h33});
    wait_idle();
    send('{`SFCE_OP_AUTO_INC, 8'h44});
    wait_idle();
    send('{`SFCE_OP_WRITE_DISABLE});
    chk("auto_disable", 8'h00, status);
    send('{`SFCE_OP_AUTO_INC, 8'h55});
    wait_idle();
    chk("auto_next", 8'h44, mem[17'h00001]);
    chk("auto_after_end", 8'hFF, mem[17'h00002]);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("status_in_reset", 8'h00, status);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("status_after_reset", 8'h0C, status);
    close_out();
  end
endmodule
